// file: verilog/mem_bus_pkg.sv
// constants, register map and carrier types for the tristate memory bus driver
// assumes one 25 MHz system clock and an AXI4-Lite host with 32-bit data
package mem_bus_pkg;
    localparam int          clk_period_ns    = 40;
    localparam int          addr_w           = 18;
    localparam int          data_w           = 32;
    localparam int          be_w             = 4;
    localparam int          cnt_w            = 10;
    // register offsets (byte addresses)
    localparam logic [7:0]  reg_ctrl         = 8'h00;
    localparam logic [7:0]  reg_timing       = 8'h04;
    localparam logic [7:0]  reg_addr         = 8'h08;
    localparam logic [7:0]  reg_wdata        = 8'h0c;
    localparam logic [7:0]  reg_cmd          = 8'h10;
    localparam logic [7:0]  reg_status       = 8'h14;
    localparam logic [7:0]  reg_rdata        = 8'h18;
    localparam logic [7:0]  reg_wait         = 8'h1c;
    // ctrl fields
    localparam int          ctrl_unit_bit    = 0;
    localparam int          ctrl_pipe_bit    = 1;
    localparam int          ctrl_span_bit    = 2;
    localparam int          ctrl_be_lsb      = 4;
    localparam int          ctrl_delay_lsb   = 8;
    // reset values, in cycles; fetch wait defaults to one
    localparam logic [31:0] ctrl_reset       = 32'h0000_00f0;
    localparam logic [31:0] timing_reset     = 32'h0000_0000;
    localparam logic [31:0] wait_reset       = 32'h0000_0001;
    localparam logic [1:0]  resp_okay        = 2'b00;
    localparam logic [1:0]  resp_slverr      = 2'b10;

    typedef enum logic [2:0] {
        st_idle   = 3'b000,
        st_setup  = 3'b001,
        st_strobe = 3'b011,
        st_hold   = 3'b010,
        st_drain  = 3'b110
    } seq_state_t;

    // pins toward the memory; strobes active low
    typedef struct packed {
        logic [addr_w-1:0] address;
        logic [be_w-1:0]   byteenable_n;
        logic              chipselect_n;
        logic              read_n;
        logic              write_n;
        logic              outputenable_n;
        logic [data_w-1:0] data_out;
        logic              data_oe;
    } mem_pins_t;
endpackage : mem_bus_pkg

// file: verilog/mem_bus_host.sv
// tristate memory bus driver with an AXI4-Lite register front end
// assumes memory data input arrives from a pin; async or fixed-latency pipelined memory
//
// What this block does
// - unpipelined read strobe equals output enable
// - async memory framed by strobes on clock edges
// - memory outputs come straight from flip-flops
// - setup delays strobe after select and address
// - async read: setup, wait, capture cycle
// - write hold keeps pins, then releases bus
// - write: setup, wait, final strobe cycle, hold
// - setup and hold independently may be zero
// - nanosecond waits round up, minimum one cycle
// - cycle waits strobe for count plus one
// - read data sampled at strobe ending edge
// - pipelined read strobe only in address phase
// - output enable held while reads outstanding
// - pipelined reads use fixed latency only
// - spanning select follows output enable
// - non-spanning select follows read strobe
// - new read may start on capture edge
// - outstanding reads drain before any write
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module mem_bus_host
    import mem_bus_pkg::*;
#(
    parameter int max_delay = 8
) (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [7:0]                    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output      logic                          s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output      logic                          s_axi_wready,
    output      logic [1:0]                    s_axi_bresp,
    output      logic                          s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [7:0]                    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output      logic                          s_axi_arready,
    output      logic [31:0]                   s_axi_rdata,
    output      logic [1:0]                    s_axi_rresp,
    output      logic                          s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    output      mem_pins_t                     mem_out,
    input  wire logic [mem_bus_pkg::data_w-1:0] mem_data_in
);
    import mem_bus_pkg::*;

    logic [31:0]       ctrl;
    logic [31:0]       timing;
    logic [31:0]       waits;
    logic [31:0]       op_addr;
    logic [31:0]       op_wdata;
    logic [31:0]       rdata;
    logic              done_flag;
    logic              aw_held;
    logic              w_held;
    logic [7:0]        aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              go;
    logic              go_write;
    seq_state_t        state;
    logic [cnt_w-1:0]  count;
    logic              is_write;
    logic [max_delay:0] pend;
    logic [data_w-1:0] din_meta;
    logic [data_w-1:0] din_sync;
    logic              pipe_start;

    // option fields
    logic       unit_ns;
    logic       pipe_mode;
    logic       spans;
    logic [3:0] delay_sel;
    assign unit_ns   = ctrl[ctrl_unit_bit];
    assign pipe_mode = ctrl[ctrl_pipe_bit];
    assign spans     = ctrl[ctrl_span_bit];
    assign delay_sel = ctrl[ctrl_delay_lsb +: 4];

    // intervals: setup [9:0], hold [25:16]; waits fetch [9:0], store [25:16]
    logic [cnt_w-1:0] pre_strobe_interval;
    logic [cnt_w-1:0] post_write_interval;
    logic [cnt_w-1:0] fetch_strobe_length;
    logic [cnt_w-1:0] store_strobe_length;
    assign pre_strobe_interval = to_cycles(timing[9:0], unit_ns, 1'b0);
    assign post_write_interval = to_cycles(timing[25:16], unit_ns, 1'b0);
    assign fetch_strobe_length = to_cycles(waits[9:0], unit_ns, 1'b1);
    assign store_strobe_length = to_cycles(waits[25:16], unit_ns, 1'b1);

    // nanoseconds round up to whole periods; strobe waits never below one cycle
    function automatic logic [cnt_w-1:0] to_cycles(input logic [9:0] v,
                                                   input logic ns, input logic strobe);
        logic [10:0] c;
        c = 11'd0;
        if (ns) begin
            c = ({1'b0, v} + 11'(clk_period_ns - 1)) / 11'(clk_period_ns);
            if (strobe && c == 11'd0)
                c = 11'd1;
        end else begin
            c = strobe ? 11'({1'b0, v} + 11'd1) : {1'b0, v};
        end
        return c[cnt_w-1:0];
    endfunction : to_cycles

    // din comes from a pin; two flops before use, din_meta samples at strobe end
    always_ff @(posedge aclk) begin
        din_meta <= mem_data_in;
        din_sync <= din_meta;
    end

    // write channel: address and data taken in either order, one write at a time
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= resp_okay;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_held && w_held) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr > reg_wait || aw_addr[1:0] != 2'b00 ||
                                 aw_addr == reg_status || aw_addr == reg_rdata)
                                ? resp_slverr : resp_okay;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register writes; a command write while busy is dropped, except a read command in st_drain
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (st[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction : merge

    logic wr_fire;
    assign wr_fire = aw_held && w_held;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl     <= ctrl_reset;
            timing   <= timing_reset;
            waits    <= wait_reset;
            op_addr  <= 32'h0;
            op_wdata <= 32'h0;
            go       <= 1'b0;
            go_write <= 1'b0;
        end else begin
            go <= 1'b0;
            if (wr_fire) begin
                if (aw_addr == reg_ctrl)
                    ctrl <= merge(ctrl, w_data, w_strb);
                else if (aw_addr == reg_timing)
                    timing <= merge(timing, w_data, w_strb);
                else if (aw_addr == reg_wait)
                    waits <= merge(waits, w_data, w_strb);
                else if (aw_addr == reg_addr)
                    op_addr <= merge(op_addr, w_data, w_strb);
                else if (aw_addr == reg_wdata)
                    op_wdata <= merge(op_wdata, w_data, w_strb);
                else if (aw_addr == reg_cmd && !go && (state == st_idle ||
                         (state == st_drain && !w_data[0]))) begin
                    go       <= 1'b1;
                    go_write <= w_data[0];
                end
            end
        end
    end

    // read channel: one read at a time, answer one cycle after acceptance
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= resp_okay;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= resp_okay;
            if (s_axi_araddr == reg_ctrl)
                s_axi_rdata <= ctrl;
            else if (s_axi_araddr == reg_timing)
                s_axi_rdata <= timing;
            else if (s_axi_araddr == reg_wait)
                s_axi_rdata <= waits;
            else if (s_axi_araddr == reg_addr)
                s_axi_rdata <= op_addr;
            else if (s_axi_araddr == reg_wdata)
                s_axi_rdata <= op_wdata;
            else if (s_axi_araddr == reg_status)
                s_axi_rdata <= {28'h0, |pend, done_flag, state != st_idle, 1'b0};
            else if (s_axi_araddr == reg_rdata)
                s_axi_rdata <= rdata;
            else begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= resp_slverr;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // pipelined read starts on a clock with the read strobe; a write command during drain is dropped
    assign pipe_start = go && !go_write && pipe_mode;

    // transfer sequencer; all pins come from flops so they cannot glitch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state    <= st_idle;
            count    <= '0;
            is_write <= 1'b0;
            mem_out  <= '{address: '0, byteenable_n: '1, chipselect_n: 1'b1,
                          read_n: 1'b1, write_n: 1'b1, outputenable_n: 1'b1,
                          data_out: '0, data_oe: 1'b0};
        end else begin
            mem_out.read_n <= 1'b1;
            case (state)
                st_idle, st_drain: begin
                    if (|pend || (pipe_start && spans))
                        mem_out.chipselect_n <= !spans;
                    else
                        mem_out.chipselect_n <= 1'b1;
                    if (pipe_start) begin
                        state                  <= st_drain;
                        mem_out.address        <= op_addr[addr_w+1:2];
                        mem_out.read_n         <= 1'b0;
                        mem_out.chipselect_n   <= 1'b0;
                        mem_out.outputenable_n <= 1'b0;
                    end else if (|pend) begin
                        mem_out.outputenable_n <= 1'b0;
                    end else if (state == st_drain) begin
                        state                  <= st_idle;
                        mem_out.outputenable_n <= 1'b1;
                    end else if (go) begin
                        // writes only start from idle, after all reads drained
                        is_write               <= go_write;
                        mem_out.address        <= op_addr[addr_w+1:2];
                        mem_out.chipselect_n   <= 1'b0;
                        mem_out.byteenable_n   <= ~ctrl[ctrl_be_lsb +: 4];
                        mem_out.data_out       <= op_wdata;
                        mem_out.data_oe        <= go_write;
                        count                  <= pre_strobe_interval;
                        state                  <= st_setup;
                        if (pre_strobe_interval == '0) begin
                            state                  <= st_strobe;
                            count                  <= go_write ? store_strobe_length
                                                               : fetch_strobe_length;
                            mem_out.write_n        <= !go_write;
                            mem_out.read_n         <= go_write;
                            mem_out.outputenable_n <= go_write;
                        end
                    end
                end
                st_setup: begin
                    count <= count - 1'b1;
                    if (count == cnt_w'(1)) begin
                        state                  <= st_strobe;
                        count                  <= is_write ? store_strobe_length
                                                           : fetch_strobe_length;
                        mem_out.write_n        <= !is_write;
                        mem_out.read_n         <= is_write;
                        mem_out.outputenable_n <= is_write;
                    end
                end
                st_strobe: begin
                    count          <= count - 1'b1;
                    mem_out.read_n <= mem_out.read_n;
                    if (count == cnt_w'(1)) begin
                        mem_out.read_n         <= 1'b1;
                        mem_out.outputenable_n <= 1'b1;
                        mem_out.write_n        <= 1'b1;
                        count                  <= post_write_interval;
                        state                  <= (is_write && post_write_interval != '0)
                                                  ? st_hold : st_idle;
                        if (!(is_write && post_write_interval != '0)) begin
                            mem_out.chipselect_n <= 1'b1;
                            mem_out.data_oe      <= 1'b0;
                            mem_out.byteenable_n <= '1;
                        end
                    end
                end
                st_hold: begin
                    count <= count - 1'b1;
                    if (count == cnt_w'(1)) begin
                        state                <= st_idle;
                        mem_out.chipselect_n <= 1'b1;
                        mem_out.data_oe      <= 1'b0;
                        mem_out.byteenable_n <= '1;
                    end
                end
                default: state <= st_idle;
            endcase
        end
    end

    // fixed-latency tracker: one bit per read in flight, sync delay included
    logic [max_delay:0] next_pend;
    always_comb begin
        next_pend = pend >> 1;
        if (pipe_start && state != st_setup && state != st_strobe && state != st_hold)
            next_pend[(int'(delay_sel) + 2 > max_delay) ? max_delay :
                      int'(delay_sel) + 2] = 1'b1;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn)
            pend <= '0;
        else
            pend <= next_pend;
    end

    // captured read data and completion flag; a new start clears the flag
    // async data is used two clocks after the strobe edge so the pin is never read raw
    logic       async_cap;
    logic [1:0] cap_dly;
    assign async_cap = state == st_strobe && !is_write && count == cnt_w'(1);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata     <= 32'h0;
            done_flag <= 1'b0;
            cap_dly   <= 2'b00;
        end else begin
            cap_dly <= {cap_dly[0], async_cap};
            if (go)
                done_flag <= 1'b0;
            if (cap_dly[1] || pend[0])
                rdata <= din_sync;
            if (cap_dly[1] || pend[0] || (state == st_hold && count == cnt_w'(1)) ||
                (state == st_strobe && is_write && count == cnt_w'(1) &&
                 post_write_interval == '0))
                done_flag <= 1'b1;
        end
    end

    // checks
    a_strobe_oe_same: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == st_strobe && !is_write) |-> mem_out.read_n == mem_out.outputenable_n)
        else $error("read strobe and output enable differ");
    a_setup_select: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == st_setup) |-> !mem_out.chipselect_n && mem_out.read_n && mem_out.write_n)
        else $error("strobe during setup");
    a_hold_pins: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == st_hold) |-> mem_out.data_oe && !mem_out.chipselect_n && mem_out.write_n)
        else $error("hold lost pins");
    a_hold_release: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == st_hold && count == cnt_w'(1)) |=> mem_out.chipselect_n && !mem_out.data_oe)
        else $error("bus not released after hold");
    a_no_write_pend: assert property (@(posedge aclk) disable iff (!aresetn)
        !mem_out.write_n |-> pend == '0)
        else $error("write while reads outstanding");
    a_oe_pending: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(|pend) && pend != '0 |-> !mem_out.outputenable_n)
        else $error("oe dropped with reads pending");
    a_pipe_strobe_one: assert property (@(posedge aclk) disable iff (!aresetn)
        (pipe_mode && $fell(mem_out.read_n) && state == st_drain) |=> $rose(mem_out.read_n)
            || (!mem_out.read_n && $past(pipe_start)))
        else $error("pipelined strobe too long");
    a_reset_idle: assert property (@(posedge aclk)
        !aresetn |=> mem_out.chipselect_n && mem_out.read_n && mem_out.write_n && !mem_out.data_oe)
        else $error("reset left bus active");
    c_async_write: cover property (@(posedge aclk) disable iff (!aresetn)
        state == st_hold ##1 state == st_idle);
    c_async_read: cover property (@(posedge aclk) disable iff (!aresetn) async_cap);
    c_pipe_back: cover property (@(posedge aclk) disable iff (!aresetn)
        pipe_start && pend[0]);
endmodule : mem_bus_host

// file: tb/mem_model.sv
// memory partner for the bus driver: async and fixed-latency pipelined reads, writes
// assumes pins change only on aclk edges; pipe and delay are set by the bench
`timescale 1ns/1ns
module mem_model
    import mem_bus_pkg::*;
(
    input  wire logic              aclk,
    input  wire mem_pins_t         pins,
    input  wire logic              pipe,
    input  wire logic [3:0]        delay,
    output      logic [data_w-1:0] data
);
    import mem_bus_pkg::*;
    logic [data_w-1:0] mem [int];
    logic [data_w:0]   line [0:15];
    logic [7:0]        cyc = 8'h00;
    // word at an address; unwritten words get a fixed pattern
    function automatic logic [data_w-1:0] word(input logic [addr_w-1:0] a);
        return mem.exists(a) ? mem[a] : {14'h0, a} ^ 32'h5a5a_0000;
    endfunction : word
    // store on strobe edges, read line holds fixed latency only
    always @(posedge aclk) begin
        cyc <= cyc + 8'h01;
        if (!pins.chipselect_n && !pins.write_n) mem[pins.address] = pins.data_out;
        for (int i = 15; i > 0; i--) line[i] <= line[i-1];
        line[0] <= {!pins.chipselect_n && !pins.read_n, word(pins.address)};
    end
    // drive only when enabled; a released bus shows a changing pattern
    always_comb begin
        if (!pins.outputenable_n && !pipe && !pins.chipselect_n) data = word(pins.address);
        else if (!pins.outputenable_n && pipe && line[delay - 4'd1][data_w])
            data = line[delay - 4'd1][31:0]; // registered edge plus latency
        else data = {4{cyc}};
    end
endmodule : mem_model

// file: tb/mem_bus_host_tb.sv
// self-checking bench for mem_bus_host: AXI4-Lite tasks, shadow memory, pin timers
// assumes mem_model answers on the memory pins
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module mem_bus_host_tb;
    import mem_bus_pkg::*;
    logic        aclk, aresetn, awv, wv, bready, arv, rready, awr, wr, bv, arr, rv, pipe;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rd, md, got, d, shadow [int];
    logic [1:0]  br, rr, resp;
    logic [3:0]  delay, ws;
    logic [19:0] a;
    mem_pins_t   pins;
    int          errors, check_count, st, last_st, pre, post, last_pre, last_post, w, n;
    bit          after, span;
    int          nsw [3] = '{0, 40, 81};
    mem_bus_host i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready),
        .mem_out(pins), .mem_data_in(md));
    mem_model i_mem (.aclk(aclk), .pins(pins), .pipe(pipe), .delay(delay), .data(md));
    initial begin
        aclk = 0;
        forever #20 aclk = ~aclk;
    end
    // pin timers; strobe length lands when the strobe ends, setup and hold once select returns high
    always @(posedge aclk) begin
        if (!pins.read_n || !pins.write_n) begin
            st++;
            after = 1;
        end else begin
            if (st) last_st = st;
            st = 0;
            if (!pins.chipselect_n && after) post++;
            else if (!pins.chipselect_n) pre++;
        end
        if (pins.chipselect_n && after) begin
            last_pre = pre;
            last_post = post;
            {pre, post, after} = 0;
        end
        if (aresetn && !pipe) `CHK("oe", pins.read_n, pins.outputenable_n)
        if (pipe) `CHK("cs", span ? pins.outputenable_n : pins.read_n, pins.chipselect_n)
    end
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dd);
        bit ad_ok, d_ok;
        @(posedge aclk);
        {awa, wd, awv, wv, bready} <= {ad, dd, 3'b111};
        do begin
            @(posedge aclk);
            ad_ok |= awr & awv;
            d_ok |= wr & wv;
            if (awr) awv <= 0;
            if (wr) wv <= 0;
        end while (!(ad_ok && d_ok));
        do @(posedge aclk); while (!bv);
        resp = br;
        bready <= 0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] ad);
        @(posedge aclk);
        {ara, arv, rready} <= {ad, 2'b11};
        do @(posedge aclk); while (!arr);
        arv <= 0;
        do @(posedge aclk); while (!rv);
        {got, resp} = {rd, rr};
        rready <= 0;
    endtask : axi_rd
    // one memory command, then poll done under a bound
    task automatic mem_op(input bit is_wr);
        axi_wr(reg_addr, {12'h0, a});
        axi_wr(reg_wdata, d);
        axi_wr(reg_cmd, {31'h0, is_wr});
        got = 0;
        for (int i = 0; i < 100 && !got[2]; i++) axi_rd(reg_status);
        `CHK("done", 1'b1, got[2])
    endtask : mem_op
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    initial begin
        #(40 * 40000);
        errors++;
        finish_test;
    end
    initial begin
        {aresetn, awv, wv, bready, arv, rready, pipe, awa, ara, wd, got} = 0;
        delay = 4'h2;
        ws = 4'hf;
        void'($urandom(41390));
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(negedge aclk);
        `CHK("cs_rst", 1'b1, pins.chipselect_n)
        `CHK("doe_rst", 1'b0, pins.data_oe)
        axi_rd(reg_ctrl);
        `CHK("ctrl", ctrl_reset, got)
        axi_rd(reg_wait);
        `CHK("wait", wait_reset, got)
        axi_rd(8'h20);
        `CHK("unmapped", resp_slverr, resp)
        axi_wr(reg_status, 32'h0);
        `CHK("ro", resp_slverr, resp)
        axi_wr(reg_wdata, 32'h1234_5678);
        ws <= 4'h3;
        axi_wr(reg_wdata, 32'h0);
        ws <= 4'hf;
        axi_rd(reg_wdata);
        `CHK("wstrb", 32'h1234_0000, got)
        $display("test reset done");
        // async write then read back, cycle and nanosecond units alternating
        for (int i = 0; i < 6; i++) begin
            n = i % 2 ? nsw[i/2] : $urandom_range(3);
            w = i % 2 ? nsw[i/2] : $urandom_range(3);
            axi_wr(reg_ctrl, 32'h0f0 | (i % 2));
            axi_wr(reg_timing, n << 16 | n);
            if (i % 2)
                n = (n + 39) / 40;
            axi_wr(reg_wait, w << 16 | w);
            w = i % 2 ? ((w + 39) / 40 > 0 ? (w + 39) / 40 : 1) : w + 1;
            {a, d} = {18'($urandom_range(255)), 2'b00, $urandom};
            shadow[a] = d;
            mem_op(1);
            `CHK("wlen", w, last_st)
            `CHK("wsetup", n, last_pre)
            `CHK("whold", n, last_post)
            mem_op(0);
            `CHK("rlen", w, last_st)
            `CHK("rsetup", n, last_pre)
            axi_rd(reg_rdata);
            `CHK("rdata", shadow[a], got)
            $display("test async %0d done", i);
        end
        // pipelined fixed-latency reads, select on read strobe or spanning
        for (int i = 0; i < 2; i++) begin
            axi_wr(reg_ctrl, 32'h2f2 | i << 2);
            {pipe, span} = {1'b1, i[0]};
            mem_op(0);
            `CHK("plen", 1, last_st)
            axi_rd(reg_rdata);
            `CHK("pdata", shadow[a], got)
            pipe = 0;
            axi_wr(reg_ctrl, 32'h0f0);
            $display("test pipe %0d done", i);
        end
        finish_test;
    end
endmodule : mem_bus_host_tb
